// ---- design/hcr_top.sv ----
// Host control and reset unit: control/status area, command decode, resets
//
// Summary of operation
// - Area answers both I/O and memory cycles
// - First eight bytes form system control block
// - Host commands steer command and receive units
// - Status word reports units, interrupt on change
// - Block holds command list and frame area pointers
// - Command blocks: non-transmit kinds or transmit block
// - Receive buffer placed right after its descriptor
// - Serial memory and management registers at 0Ch and 10h
// - No frames moved until configure has completed
// - Reset pin clears every register, bus config too
// - Full software reset keeps only bus config and self-test address
// - Selective reset keeps bases, split size, counters, setup
// - Selective reset idles both units, drops rest
// - Self-test: selective reset before, full reset after
`timescale 1ns/100ps
module hcr_top (
  input  wire logic                clock,
  input  wire logic                rst_b,
  // Host access port into the control/status area
  input  wire logic                acc_req,
  input  wire logic                acc_mem,
  input  wire logic                acc_wr,
  input  wire logic [4:0]          acc_addr,
  input  wire logic [3:0]          acc_be,
  input  wire logic [31:0]         acc_wdata,
  output logic                     acc_ack_r,
  output logic [31:0]              acc_rdata_r,
  // Bus configuration space write
  input  wire logic                buscfg_wr,
  input  wire logic [1:0]          buscfg_wdata,
  output logic [1:0]               buscfg_r,
  // Command and receive engine events
  input  wire logic                cu_evt_susp,
  input  wire logic                cu_evt_idle,
  input  wire logic                ru_evt_susp,
  input  wire logic                ru_evt_idle,
  input  wire logic                cmd_done,
  input  wire logic                frame_rx,
  input  wire logic [2:0]          cb_opcode,
  input  wire logic                cfg_done,
  input  wire logic                addr_done,
  input  wire logic                grp_done,
  input  wire logic                hds_wr,
  input  wire logic [15:0]         hds_val,
  input  wire logic                err_inc,
  input  wire logic [31:0]         rfd_addr,
  input  wire logic                ee_data_in,
  // Outputs to the engines and the host
  output logic                     irq_r,
  output logic [31:0]              cbl_ptr_r,
  output logic [31:0]              rfa_ptr_r,
  output logic [31:0]              rx_buf_addr_r,
  output logic                     cb_is_tx_r,
  output logic                     tx_enable_r,
  output logic                     rx_enable_r,
  output logic                     configured_r,
  output logic                     addr_setup_r,
  output logic                     grp_setup_r,
  output logic [15:0]              hds_r,
  output logic [15:0]              err_cnt_r,
  output logic [15:0]              ee_ctrl_r,
  output logic [31:0]              mgmt_ctrl_r,
  output logic                     mgmt_go_r,
  output logic                     self_test_run_r,
  output logic [27:0]              self_test_addr_r
);
  import hcr_pkg::*;

  // ==========================================================================
  // Declarations
  hcr_unit_if            cu_if ();          // Command unit link
  hcr_unit_if            ru_if ();          // Receive unit link
  logic [31:0]           gp_r;              // General pointer
  logic [3:0]            evt_r;             // Sticky events
  logic                  irq_mask_r;        // Interrupt mask
  logic                  full_clr_r;        // Full software reset pulse
  logic                  sel_clr_r;         // Selective reset pulse
  hcr_st_e               st_r;              // Self-test sequencer
  logic [ST_CNT_W-1:0]   st_cnt_r;          // Self-test cycle count
  logic                  hit;               // Access accepted
  logic                  wr_cmd;            // Command bytes written
  logic                  wr_port;           // Port command written
  logic [31:0]           stat_word;         // Status/command word readback
  logic [3:0]            evt_set;           // Event sources this cycle
  logic [3:0]            evt_clr;           // Host acknowledges

  // ==========================================================================
  // Decode of a host command field into a unit command
  function automatic hcr_ucmd_e hcr_decode(input logic [3:0] code);
    unique case (code)
      HC_START:     hcr_decode = UC_START;
      HC_RESUME:    hcr_decode = UC_RESUME;
      HC_ABORT:     hcr_decode = UC_ABORT;
      HC_LOAD_BASE: hcr_decode = UC_LOAD_BASE;
      default:      hcr_decode = UC_NOP;  // Unused codes do nothing
    endcase
  endfunction

  // ==========================================================================
  // Access qualification: either space, gated by its enable
  assign hit     = acc_req && (acc_mem ? buscfg_r[1] : buscfg_r[0]);
  assign wr_cmd  = hit && acc_wr && acc_addr == OFS_SCB_STAT_CMD && acc_be[2];
  assign wr_port = hit && acc_wr && acc_addr == OFS_PORT && acc_be[0];

  // ==========================================================================
  // Unit links
  assign cu_if.cmd      = wr_cmd ? hcr_decode(acc_wdata[FLD_CU_CMD +: 4]) : UC_NOP;
  assign ru_if.cmd      = wr_cmd ? hcr_decode({1'b0, acc_wdata[FLD_RU_CMD +: 3]})
                                 : UC_NOP;
  assign cu_if.gp       = gp_r;
  assign ru_if.gp       = gp_r;
  assign cu_if.clr_full = full_clr_r;
  assign ru_if.clr_full = full_clr_r;
  assign cu_if.clr_sel  = sel_clr_r;
  assign ru_if.clr_sel  = sel_clr_r;
  assign cu_if.evt_susp = cu_evt_susp;
  assign cu_if.evt_idle = cu_evt_idle;
  assign ru_if.evt_susp = ru_evt_susp;
  assign ru_if.evt_idle = ru_evt_idle;

  hcr_unit u_cu (
    .clock (clock),
    .rst_b (rst_b),
    .u     (cu_if)
  );

  hcr_unit u_ru (
    .clock (clock),
    .rst_b (rst_b),
    .u     (ru_if)
  );

  // ==========================================================================
  // Bus configuration: only the reset pin clears it
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      buscfg_r <= RST_BUSCFG;
    end else if (buscfg_wr) begin
      buscfg_r <= buscfg_wdata;  // Untouched by any port reset
    end
  end

  // ==========================================================================
  // Port commands and self-test sequencing
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      full_clr_r       <= 1'b0;
      sel_clr_r        <= 1'b0;
      st_r             <= ST_OFF;
      st_cnt_r         <= '0;
      self_test_run_r  <= 1'b0;
      self_test_addr_r <= '0;
    end else begin
      full_clr_r <= 1'b0;
      sel_clr_r  <= 1'b0;
      unique case (st_r)
        ST_OFF: begin
          if (wr_port) begin
            if (acc_wdata[3:0] == PORT_SOFT_RESET) begin
              full_clr_r <= 1'b1;
            end else if (acc_wdata[3:0] == PORT_SEL_RESET) begin
              sel_clr_r <= 1'b1;
            end else if (acc_wdata[3:0] == PORT_SELF_TEST) begin
              sel_clr_r        <= 1'b1;  // Selective reset before
              st_r             <= ST_RUN;
              st_cnt_r         <= ST_CNT_W'(ST_CYCLES - 1);
              self_test_run_r  <= 1'b1;
              self_test_addr_r <= acc_wdata[31:4];  // Paragraph aligned
            end
          end
        end
        ST_RUN: begin
          // Port writes are ignored while the test runs
          if (st_cnt_r == '0) begin
            full_clr_r      <= 1'b1;  // Full reset once test ends
            st_r            <= ST_OFF;
            self_test_run_r <= 1'b0;
          end else begin
            st_cnt_r <= st_cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Settings kept across a selective reset, lost on a full one
  always_ff @(posedge clock) begin
    if (!rst_b || full_clr_r) begin
      configured_r <= 1'b0;
      addr_setup_r <= 1'b0;
      grp_setup_r  <= 1'b0;
      hds_r        <= RST_HALF;
      err_cnt_r    <= RST_HALF;
    end else begin
      // Selective reset does not touch these
      if (cfg_done)  configured_r <= 1'b1;
      if (addr_done) addr_setup_r <= 1'b1;
      if (grp_done)  grp_setup_r  <= 1'b1;
      if (hds_wr)    hds_r        <= hds_val;
      if (err_inc && err_cnt_r != 16'hffff) err_cnt_r <= err_cnt_r + 16'h0001;
    end
  end

  // ==========================================================================
  // Volatile setup state: cleared by every reset flavour
  always_ff @(posedge clock) begin
    if (!rst_b || full_clr_r || sel_clr_r) begin
      gp_r        <= RST_WORD;
      irq_mask_r  <= 1'b0;
      ee_ctrl_r   <= RST_HALF;
      mgmt_ctrl_r <= RST_WORD;
      mgmt_go_r   <= 1'b0;
    end else begin
      mgmt_go_r <= 1'b0;
      if (hit && acc_wr) begin
        unique case (acc_addr)
          OFS_SCB_STAT_CMD: if (acc_be[3]) irq_mask_r <= acc_wdata[FLD_IRQ_MASK];
          OFS_SCB_GP: begin
            for (int b = 0; b < 4; b++) begin
              if (acc_be[b]) gp_r[b*8 +: 8] <= acc_wdata[b*8 +: 8];
            end
          end
          OFS_EE_CTRL: begin
            if (acc_be[0]) ee_ctrl_r[7:0]  <= acc_wdata[7:0];
            if (acc_be[1]) ee_ctrl_r[15:8] <= acc_wdata[15:8];
          end
          OFS_MGMT_CTRL: begin
            mgmt_ctrl_r <= acc_wdata;
            mgmt_go_r   <= 1'b1;  // Start the serial engine
          end
          default: ;  // Unmapped writes are dropped
        endcase
      end
    end
  end

  // ==========================================================================
  // Sticky status events; a set in the clearing cycle wins
  assign evt_set = {cmd_done, frame_rx, cu_if.chg, ru_if.chg};
  assign evt_clr = (hit && acc_wr && acc_addr == OFS_SCB_STAT_CMD && acc_be[1])
                   ? acc_wdata[FLD_EVT_LO +: 4] : 4'h0;

  always_ff @(posedge clock) begin
    if (!rst_b || full_clr_r || sel_clr_r) begin
      evt_r <= 4'h0;
    end else begin
      evt_r <= (evt_r & ~evt_clr) | evt_set;
    end
  end

  // ==========================================================================
  // Interrupt, raised while any status event is unacknowledged and the interrupt mask is clear
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |evt_r && !irq_mask_r;
    end
  end

  // ==========================================================================
  // Readback of the area
  always_comb begin
    stat_word                            = RST_WORD;
    stat_word[FLD_EVT_LO +: 4]           = evt_r;
    stat_word[FLD_CU_STATE +: 2]         = cu_if.state;
    stat_word[FLD_RU_STATE +: 2]         = ru_if.state;
    stat_word[FLD_IRQ_MASK]              = irq_mask_r;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      acc_ack_r   <= 1'b0;
      acc_rdata_r <= RST_WORD;
    end else begin
      acc_ack_r <= hit;
      if (hit && !acc_wr) begin
        unique case (acc_addr)
          OFS_SCB_STAT_CMD: acc_rdata_r <= stat_word;
          OFS_SCB_GP:       acc_rdata_r <= gp_r;
          OFS_PORT:         acc_rdata_r <= {self_test_addr_r, 3'h0, self_test_run_r};
          OFS_EE_CTRL:      acc_rdata_r <= {16'h0000, ee_ctrl_r[15:FLD_EE_DIN+1],
                                            ee_data_in, ee_ctrl_r[FLD_EE_DIN-1:0]};
          OFS_MGMT_CTRL:    acc_rdata_r <= mgmt_ctrl_r;
          default:          acc_rdata_r <= RST_WORD;  // Unmapped reads zero
        endcase
      end
    end
  end

  // ==========================================================================
  // Engine-facing outputs
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cbl_ptr_r     <= RST_WORD;
      rfa_ptr_r     <= RST_WORD;
      rx_buf_addr_r <= RST_WORD;
      cb_is_tx_r    <= 1'b0;
      tx_enable_r   <= 1'b0;
      rx_enable_r   <= 1'b0;
    end else begin
      cbl_ptr_r     <= cu_if.ptr;
      rfa_ptr_r     <= ru_if.ptr;
      rx_buf_addr_r <= rfd_addr + RFD_HDR_BYTES;  // Simplified model only
      cb_is_tx_r    <= cb_opcode == CB_OP_TRANSMIT;
      // Nothing moves on the wire before configure completes
      tx_enable_r   <= configured_r && cu_if.state == U_ACTIVE;
      rx_enable_r   <= configured_r && ru_if.state == U_ACTIVE;
    end
  end

endmodule // hcr_top

// ---- design/hcr_pkg.sv ----
// Package of constants and types for the host control and reset unit
package hcr_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int CLK_MHZ     = 250;                                // System clock rate
  localparam int ST_TIME_NS  = 2000;                               // Self-test run time
  localparam int ST_CYCLES   = (ST_TIME_NS * CLK_MHZ + 999) / 1000; // Rounded up
  localparam int ST_CNT_W    = 10;                                 // Counter width

  // ==========================================================================
  // Control/status area byte offsets (word aligned)
  localparam logic [4:0] OFS_SCB_STAT_CMD = 5'h00; // Status word and command word
  localparam logic [4:0] OFS_SCB_GP       = 5'h04; // General pointer
  localparam logic [4:0] OFS_PORT         = 5'h08; // Port command
  localparam logic [4:0] OFS_EE_CTRL      = 5'h0c; // Serial memory control
  localparam logic [4:0] OFS_MGMT_CTRL    = 5'h10; // Management data port control

  // ==========================================================================
  // Field positions in the status/command word
  localparam int FLD_CU_STATE = 6;   // Command unit state, 2 bits
  localparam int FLD_RU_STATE = 4;   // Receive unit state, 2 bits
  localparam int FLD_EVT_LO   = 12;  // Sticky events, bits 15:12
  localparam int FLD_RU_CMD   = 16;  // Receive unit command, 3 bits
  localparam int FLD_CU_CMD   = 20;  // Command unit command, 4 bits
  localparam int FLD_IRQ_MASK = 24;  // Interrupt mask bit
  localparam int FLD_EE_DIN   = 3;   // Serial memory data-in bit in control word

  // Sticky event bit indices inside the 4-bit event field
  localparam int EVT_CMD_DONE = 3;
  localparam int EVT_FRAME_RX = 2;
  localparam int EVT_CU_CHG   = 1;
  localparam int EVT_RU_CHG   = 0;

  // Port command opcodes
  localparam logic [3:0] PORT_SOFT_RESET = 4'h0;
  localparam logic [3:0] PORT_SELF_TEST  = 4'h1;
  localparam logic [3:0] PORT_SEL_RESET  = 4'h2;

  // Host command codes written into the command fields
  localparam logic [3:0] HC_START     = 4'h1;
  localparam logic [3:0] HC_RESUME    = 4'h2;
  localparam logic [3:0] HC_ABORT     = 4'h4;
  localparam logic [3:0] HC_LOAD_BASE = 4'h6;

  // Command block opcode for a transmit block; the others are non-transmit
  localparam logic [2:0] CB_OP_TRANSMIT = 3'h4;

  // Receive data buffer sits right after the descriptor header
  localparam logic [31:0] RFD_HDR_BYTES = 32'h0000_0010;

  // Reset values
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [15:0] RST_HALF   = 16'h0000;
  localparam logic [1:0]  RST_BUSCFG = 2'h0;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {U_IDLE, U_SUSPENDED, U_ACTIVE} hcr_ustate_e;
  typedef enum logic [2:0] {UC_NOP, UC_START, UC_RESUME, UC_LOAD_BASE, UC_ABORT} hcr_ucmd_e;
  typedef enum logic {ST_OFF, ST_RUN} hcr_st_e;

endpackage

// ---- design/hcr_unit_if.sv ----
// Interface between the control core and one unit state keeper
`timescale 1ns/100ps
interface hcr_unit_if;
  import hcr_pkg::*;
  hcr_ucmd_e   cmd;       // One-cycle host command
  logic [31:0] gp;        // General pointer value
  logic        clr_full;  // Full software reset pulse
  logic        clr_sel;   // Selective reset pulse
  logic        evt_susp;  // Engine reports suspension
  logic        evt_idle;  // Engine reports idle
  hcr_ustate_e state;     // Unit state
  logic [31:0] base;      // Unit base register
  logic [31:0] ptr;       // Physical list start
  logic        chg;       // State changed pulse

  modport ctl  (output cmd, gp, clr_full, clr_sel, evt_susp, evt_idle,
                input state, base, ptr, chg);
  modport unit (input cmd, gp, clr_full, clr_sel, evt_susp, evt_idle,
                output state, base, ptr, chg);
endinterface

// ---- design/hcr_unit.sv ----
// State keeper for one unit: idle/suspended/active, base and list pointer
`timescale 1ns/100ps
module hcr_unit (
  input  wire logic clock,
  input  wire logic rst_b,
  hcr_unit_if.unit  u
);
  import hcr_pkg::*;

  hcr_ustate_e state_r;    // Current state
  hcr_ustate_e state_nxt;  // Next state

  // ==========================================================================
  // Next state from host command, then engine events
  always_comb begin
    state_nxt = state_r;
    unique case (u.cmd)
      UC_START:     state_nxt = U_ACTIVE;
      UC_RESUME:    if (state_r == U_SUSPENDED) state_nxt = U_ACTIVE;
      UC_ABORT:     state_nxt = U_IDLE;
      UC_LOAD_BASE: state_nxt = state_r;
      UC_NOP: begin
        // Engine events only count while no host command lands
        if (u.evt_idle) begin
          state_nxt = U_IDLE;
        end else if (u.evt_susp && state_r == U_ACTIVE) begin
          state_nxt = U_SUSPENDED;
        end
      end
    endcase
    if (u.clr_full || u.clr_sel) state_nxt = U_IDLE;
  end

  // ==========================================================================
  // State register and change pulse
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_r <= U_IDLE;
      u.chg   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      u.chg   <= (state_nxt != state_r) && !u.clr_full && !u.clr_sel;
    end
  end

  // ==========================================================================
  // Base register: survives a selective reset, not a full one
  always_ff @(posedge clock) begin
    if (!rst_b || u.clr_full) begin
      u.base <= RST_WORD;
    end else if (u.cmd == UC_LOAD_BASE && state_r == U_IDLE) begin
      u.base <= u.gp;  // Loading is only legal while idle
    end
  end

  // ==========================================================================
  // List start pointer, base plus offset
  always_ff @(posedge clock) begin
    if (!rst_b || u.clr_full || u.clr_sel) begin
      u.ptr <= RST_WORD;
    end else if (u.cmd == UC_START) begin
      u.ptr <= u.base + u.gp;
    end
  end

  assign u.state = state_r;

endmodule // hcr_unit

// ---- tb/hcr_chk.sv ----
// Port-level checker of the host control and reset unit
`timescale 1ns/100ps
module hcr_chk
  import hcr_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_b,
  input wire logic        acc_req,
  input wire logic        acc_mem,
  input wire logic        acc_wr,
  input wire logic [4:0]  acc_addr,
  input wire logic [3:0]  acc_be,
  input wire logic [31:0] acc_wdata,
  input wire logic        acc_ack_r,
  input wire logic        buscfg_wr,
  input wire logic [1:0]  buscfg_r,
  input wire logic [2:0]  cb_opcode,
  input wire logic        cb_is_tx_r,
  input wire logic [31:0] rfd_addr,
  input wire logic [31:0] rx_buf_addr_r,
  input wire logic        irq_r,
  input wire logic        tx_enable_r,
  input wire logic        configured_r,
  input wire logic        mgmt_go_r,
  input wire logic        self_test_run_r
);
  import hcr_pkg::*;
  // ==========
  // Clocking and the access steps
  default clocking cb_clk @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Request in an enabled space
  sequence acc_ok;
    acc_req && (acc_mem ? buscfg_r[1] : buscfg_r[0]);
  endsequence
  // Self-test port write while idle
  sequence st_go;
    acc_ok ##0 (acc_wr && acc_addr == OFS_PORT && acc_be[0] &&
                acc_wdata[3:0] == PORT_SELF_TEST && !self_test_run_r);
  endsequence
  // ==========
  // Assertions
  ack_on_take_a: assert property (acc_ok |=> acc_ack_r)
    else $error("accepted access got no ack");
  ack_cause_a: assert property (acc_ack_r |-> $past(acc_req))
    else $error("ack without request");
  bus_cfg_keep_a: assert property (!buscfg_wr |=> $stable(buscfg_r))
    else $error("bus config changed without a load");
  rst_clear_a: assert property ($rose(rst_b) |-> buscfg_r == 2'h0 && !irq_r && !configured_r)
    else $error("state left after pin reset");
  tx_needs_cfg_a: assert property (tx_enable_r |-> configured_r || $past(configured_r))
    else $error("transmit enabled before configure");
  rx_buf_next_a: assert property ($changed(rfd_addr) ##1 $stable(rfd_addr) [*2]
    |-> rx_buf_addr_r == rfd_addr + RFD_HDR_BYTES) else $error("buffer not after descriptor");
  tx_kind_a: assert property (cb_is_tx_r |-> $past(cb_opcode) == CB_OP_TRANSMIT)
    else $error("non-transmit block flagged as transmit");
  mgmt_go_a: assert property (acc_ok ##0 (acc_wr && acc_addr == OFS_MGMT_CTRL) |=> mgmt_go_r)
    else $error("management write gave no start pulse");
  st_start_a: assert property (st_go |=> self_test_run_r [*8])
    else $error("self-test did not start and run");
  st_end_a: assert property ($fell(self_test_run_r) |-> ##[0:4] !configured_r)
    else $error("no full clear after self-test");
endmodule // hcr_chk

bind hcr_top hcr_chk i_chk (.*);

// ---- tb/hcr_eng_model.sv ----
// Model of the engines that report events to the unit
`timescale 1ns/100ps
module hcr_eng_model (
  input wire logic    clock,
  output logic [10:0] evt,
  output logic [2:0]  cb_opcode,
  output logic [31:0] rfd_addr,
  output logic [15:0] hds_val,
  output logic        ee_data_in
);
  // One-cycle engine pulse, launched just after an edge
  task automatic fire(input int n);
    @(posedge clock);
    #1 evt[n] = 1'b1;
    @(posedge clock);
    #1 evt[n] = 1'b0;
  endtask
  // Current block and descriptor; its buffer follows it directly
  task automatic set(input logic [2:0] op, input logic [31:0] ra, input logic [15:0] hv,
                     input logic din);
    @(posedge clock);
    #1 {cb_opcode, rfd_addr, hds_val, ee_data_in} = {op, ra, hv, din};
  endtask
  initial {evt, cb_opcode, rfd_addr, hds_val, ee_data_in} = '0;
endmodule // hcr_eng_model

// ---- tb/tb_top.sv ----
// Self-checking bench of the host control and reset unit
`timescale 1ns/100ps
module tb_top;
  import hcr_pkg::*;
  // ==========
  // Signals carry the port names, so both instances connect by name
  logic        clock, rst_b, acc_req, acc_mem, acc_wr, buscfg_wr, acc_ack_r, irq_r, ak;
  logic        cb_is_tx_r, tx_enable_r, rx_enable_r, configured_r, addr_setup_r, grp_setup_r;
  logic        mgmt_go_r, self_test_run_r, ee_data_in, cu_evt_susp, cu_evt_idle, ru_evt_susp;
  logic        ru_evt_idle, cmd_done, frame_rx, cfg_done, addr_done, grp_done, hds_wr, err_inc;
  logic [1:0]  buscfg_wdata, buscfg_r;
  logic [2:0]  cb_opcode;
  logic [3:0]  acc_be;
  logic [4:0]  acc_addr;
  logic [10:0] evt;
  logic [15:0] hds_val, hds_r, err_cnt_r, ee_ctrl_r;
  logic [27:0] self_test_addr_r;
  logic [31:0] acc_wdata, acc_rdata_r, cbl_ptr_r, rfa_ptr_r, rx_buf_addr_r, mgmt_ctrl_r;
  logic [31:0] rfd_addr, rd;
  int          bad_count, checks_done, i;
  // Engine pulses in one vector, err_inc at bit 0
  assign {cu_evt_susp, cu_evt_idle, ru_evt_susp, ru_evt_idle, cmd_done, frame_rx, cfg_done,
          addr_done, grp_done, hds_wr, err_inc} = evt;
  hcr_top i_dut (.*);
  hcr_eng_model i_eng (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ==========
  // Access and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Request stands one edge; the answer is sampled in the cycle after
  task automatic acc(input logic w, m, input logic [4:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    @(posedge clock);
    #1 {acc_req, acc_wr, acc_mem, acc_addr, acc_be, acc_wdata} = {1'b1, w, m, a, b, d};
    @(posedge clock);
    #1 acc_req = 1'b0;
    ak = acc_ack_r;
    rd = acc_rdata_r;
  endtask
  function automatic logic [31:0] ucmd(input logic [3:0] cu, input logic [3:0] ru);
    return {8'h00, cu, 1'b0, ru[2:0], 16'h0000};
  endfunction
  task automatic summarize();
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    {rst_b, acc_req, acc_mem, acc_wr, acc_addr, acc_be, acc_wdata, buscfg_wr, buscfg_wdata} = '0;
    bad_count = 0;
    checks_done = 0;
    tick(3);
    rst_b = 1'b1;
    chk(buscfg_r, 2'h0);
    acc(1'b0, 1'b1, OFS_SCB_STAT_CMD, 4'hf, '0);
    chk(ak, 1'b0);
    {buscfg_wr, buscfg_wdata} = 3'h7;
    tick(1);
    buscfg_wr = 1'b0;
    for (i = 0; i < 2; i++) begin
      acc(1'b0, i[0], OFS_SCB_STAT_CMD, 4'hf, '0);
      chk(ak, 1'b1);
      chk(rd[7:4], 4'h0);
    end
    // Bases, then both units started from one pointer
    acc(1'b1, 1'b0, OFS_SCB_GP, 4'hf, 32'h1000_0000);
    acc(1'b1, 1'b1, OFS_SCB_STAT_CMD, 4'h4, ucmd(HC_LOAD_BASE, HC_LOAD_BASE));
    acc(1'b1, 1'b0, OFS_SCB_GP, 4'hf, 32'h0000_0200);
    acc(1'b1, 1'b1, OFS_SCB_STAT_CMD, 4'h4, ucmd(HC_START, HC_START));
    tick(3);
    chk(cbl_ptr_r, 32'h1000_0200);
    chk(rfa_ptr_r, 32'h1000_0200);
    chk(irq_r, 1'b1);
    chk(tx_enable_r, 1'b0);
    acc(1'b0, 1'b0, OFS_SCB_STAT_CMD, 4'hf, '0);
    chk(rd[7:4], 4'ha);
    chk(rd[13:12], 2'h3);
    acc(1'b1, 1'b0, OFS_SCB_STAT_CMD, 4'h8, 32'h0100_0000);
    tick(1);
    chk(irq_r, 1'b0);
    acc(1'b1, 1'b0, OFS_SCB_STAT_CMD, 4'ha, 32'h0000_f000);
    tick(1);
    chk(irq_r, 1'b0);
    // Error count, split size, group, address, configure, frame event
    i_eng.set(3'h0, 32'h0, 16'h0123, 1'b1);
    for (i = 0; i < 6; i++) i_eng.fire(i);
    tick(2);
    chk({irq_r, configured_r, tx_enable_r, rx_enable_r}, 4'hf);
    chk({hds_r, err_cnt_r}, 32'h0123_0001);
    for (i = 0; i < 8; i++) begin
      i_eng.set(i[2:0], 32'h100 * i, 16'h0123, 1'b1);
      tick(2);
      chk(cb_is_tx_r, i == 4);
      chk(rx_buf_addr_r, 32'h100 * i + RFD_HDR_BYTES);
    end
    acc(1'b0, 1'b0, OFS_EE_CTRL, 4'hf, '0);
    chk(rd[FLD_EE_DIN], 1'b1);
    acc(1'b1, 1'b0, OFS_EE_CTRL, 4'h3, 32'h0000_abc5);
    chk(ee_ctrl_r, 16'habc5);
    // Engine suspends the command unit, host resumes it
    i_eng.fire(10);
    acc(1'b0, 1'b0, OFS_SCB_STAT_CMD, 4'hf, '0);
    chk(rd[7:4], 4'h6);
    acc(1'b1, 1'b0, OFS_SCB_STAT_CMD, 4'h4, ucmd(HC_RESUME, 4'h0));
    acc(1'b0, 1'b0, OFS_SCB_STAT_CMD, 4'hf, '0);
    chk(rd[7:4], 4'ha);
    acc(1'b1, 1'b1, OFS_MGMT_CTRL, 4'hf, 32'h1234_5678);
    chk(mgmt_ctrl_r, 32'h1234_5678);
    acc(1'b0, 1'b1, 5'h14, 4'hf, '0);
    chk({ak, rd}, 33'h1_0000_0000);
    // Selective reset keeps setup, idles units
    acc(1'b1, 1'b0, OFS_PORT, 4'h1, {28'h0, PORT_SEL_RESET});
    tick(3);
    chk({hds_r, err_cnt_r}, 32'h0123_0001);
    chk({configured_r, addr_setup_r, grp_setup_r}, 3'h7);
    chk({mgmt_ctrl_r, tx_enable_r, irq_r}, 34'h0);
    acc(1'b0, 1'b0, OFS_SCB_STAT_CMD, 4'hf, '0);
    chk(rd[7:4], 4'h0);
    acc(1'b1, 1'b0, OFS_SCB_GP, 4'hf, '0);
    acc(1'b1, 1'b0, OFS_SCB_STAT_CMD, 4'h4, ucmd(HC_START, 4'h0));
    tick(3);
    chk(cbl_ptr_r, 32'h1000_0000);
    // Self-test, bounded wait for its end
    acc(1'b1, 1'b0, OFS_PORT, 4'hf, 32'habcd_ef01);
    tick(1);
    chk(self_test_run_r, 1'b1);
    chk(self_test_addr_r, 28'habc_def0);
    for (i = 0; i < 600 && self_test_run_r === 1'b1; i++) tick(1);
    chk(self_test_run_r, 1'b0);
    if (self_test_run_r !== 1'b0) summarize();
    tick(3);
    chk({configured_r, addr_setup_r, hds_r, err_cnt_r}, 34'h0);
    chk(buscfg_r, 2'h3);
    acc(1'b1, 1'b0, OFS_SCB_GP, 4'hf, 32'h0000_0040);
    acc(1'b1, 1'b0, OFS_SCB_STAT_CMD, 4'h4, ucmd(HC_START, 4'h0));
    tick(3);
    chk(cbl_ptr_r, 32'h0000_0040);
    // Software reset, then the pin
    i_eng.fire(1);
    acc(1'b1, 1'b1, OFS_PORT, 4'h1, {28'h0, PORT_SOFT_RESET});
    tick(3);
    chk({buscfg_r, hds_r}, 18'h3_0000);
    rst_b = 1'b0;
    tick(3);
    rst_b = 1'b1;
    chk(buscfg_r, 2'h0);
    summarize();
  end
endmodule // tb_top
